// file: core/ssa_consts.svh
`ifndef SSA_CONSTS_SVH
`define SSA_CONSTS_SVH

`define SSA_OFS_CTRL    8'h00
`define SSA_OFS_SYNC    8'h04
`define SSA_OFS_MASK    8'h08
`define SSA_OFS_CMD     8'h0C
`define SSA_OFS_OFLAGS  8'h10
`define SSA_OFS_TXDATA  8'h14
`define SSA_OFS_RXDATA  8'h18
`define SSA_OFS_STATUS  8'h1C

`define SSA_CTRL_RST    6'h00
`define SSA_SYNC_RST    8'h16
`define SSA_MASK_RST    8'h00
`define SSA_OFL_RST     3'h0
`define SSA_SEL_ADDR    8'hF0

`define SSA_MASK_RX_BIT 2
`define SSA_MASK_TX_BIT 1

`define SSA_CMD_SEL_BIT  8
`define SSA_CMD_INIT_BIT 9
`define SSA_CMD_DEVICE_CLEAR_CMD_BIT 10

`define SSA_ST_RXA_BIT  0
`define SSA_ST_TXN_BIT  1
`define SSA_ST_PERR_BIT 2
`define SSA_ST_SEL_BIT  3
`define SSA_ST_CTS_BIT  4
`define SSA_ST_IRQ_BIT  5
`define SSA_ST_LOCK_BIT 6

`define SSA_FRAME_MAX   4'd9

`endif

// file: core/ssa_pkg.sv
`default_nettype none

package ssa_pkg;

    typedef struct packed {
        logic       sup;
        logic       ien;
        logic       odd;
        logic       par;
        logic [1:0] wcode;
    } ssa_ctrl_t;

    typedef struct packed {
        logic brk;
        logic rts;
        logic dtr;
    } ssa_oflags_t;

    typedef enum logic {
        SSA_HUNT = 1'b0,
        SSA_LOCK = 1'b1
    } ssa_rx_state_t;

endpackage : ssa_pkg

`default_nettype wire

// file: core/ssa_top.sv
//Contract
// - Device clear drops the received-character-available flag.
// - Reading the received character drops the received-character-available flag.
// - Nothing is delivered before a sync character matching the programmed value.
// - Any 8-bit value serves as sync character for both directions.
// - Data width selectable as 8, 7, 6 or 5 bits.
// - Even or odd parity, generated on transmit and checked on receive.
// - A character arriving while available flag set raises parity-or-overrun.
// - Initialize clears the parity-or-overrun flag.
// - Device clear clears the parity-or-overrun flag.
// - After a read, a further good character leaves parity-or-overrun clear.
// - Break forcing the line mid-character yields a parity error.
// - Service mask zero: no interrupt for receive or transmit.
// - Receive mask bit set: interrupt only on received character.
// - Device clear resets a pending interrupt.
// - Transmit mask bit: interrupt only when transmitter can take a character.
// - Suppression option: no sync fill while request or clear to send is low.
// - Without the option sync fill continues regardless of handshake lines.
// - Initialize drops the received-character-available flag.
// - Transmit-needed sets on first select, clears on load, sets after sending.
// - Commands act only after select with matching address; initialize deselects. The code lets initialize act without select.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ssa_consts.svh"

module ssa_top #(
    parameter int         ADDR_W   = 8,
    parameter logic [7:0] SEL_ADDR = `SSA_SEL_ADDR
) (
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic              LCLK_I,
    input  wire logic              RXD_I,
    input  wire logic              CTS_I,
    output logic                   TXD_O,
    output logic                   RTS_O,
    output logic                   DTR_O,
    output logic                   IRQ_O
);

    if (ADDR_W < 5) begin : g_chk
        $error("ADDR_W too small for the register map");
    end

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        return (a[1:0] == 2'b00) && (o <= `SSA_OFS_STATUS) && (a == ADDR_W'(o));
    endfunction : is_mapped

    function automatic logic [3:0] frame_len(input ssa_pkg::ssa_ctrl_t c);
        return 4'd8 - {2'b00, c.wcode} + {3'b000, c.par};
    endfunction : frame_len

    // Data in the low bits, parity just above the last data bit
    function automatic logic [8:0] build_frame(input logic [7:0] d,
                                               input ssa_pkg::ssa_ctrl_t c);
        logic [7:0] m;
        logic       p;
        m = d & (8'hFF >> c.wcode);
        p = (^m) ^ c.odd;
        return c.par ? ({1'b0, m} | ({8'h00, p} << (4'd8 - {2'b00, c.wcode}))) : {1'b0, m};
    endfunction : build_frame

    ssa_pkg::ssa_ctrl_t   ctrl_ff;
    ssa_pkg::ssa_oflags_t ofl_ff;
    ssa_pkg::ssa_rx_state_t rx_state_ff;
    logic [7:0]  sync_ff;
    logic [7:0]  mask_ff;
    logic        sel_ff;
    logic        tx_need_ff;
    logic        tx_full_ff;
    logic [7:0]  tx_buf_ff;
    logic [8:0]  tx_sh_ff;
    logic [3:0]  tx_cnt_ff;
    logic        tx_data_ff;
    logic        txd_ff;
    logic [8:0]  rx_sh_ff;
    logic [3:0]  rx_cnt_ff;
    logic [7:0]  rx_data_ff;
    logic        rx_avail_ff;
    logic        perr_ff;
    logic        irq_ff;
    logic [31:0] prdata_ff;
    logic        lclk_q1_ff;
    logic        lclk_q2_ff;
    logic        lclk_q3_ff;
    logic        rxd_q1_ff;
    logic        rxd_q2_ff;
    logic        cts_q1_ff;
    logic        cts_q2_ff;

    // Link side inputs pass two flops; the third flop only serves edge finding
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            lclk_q1_ff <= 1'b0;
            lclk_q2_ff <= 1'b0;
            lclk_q3_ff <= 1'b0;
            rxd_q1_ff  <= 1'b1;
            rxd_q2_ff  <= 1'b1;
            cts_q1_ff  <= 1'b0;
            cts_q2_ff  <= 1'b0;
        end else begin
            lclk_q1_ff <= LCLK_I;
            lclk_q2_ff <= lclk_q1_ff;
            lclk_q3_ff <= lclk_q2_ff;
            rxd_q1_ff  <= RXD_I;
            rxd_q2_ff  <= rxd_q1_ff;
            cts_q1_ff  <= CTS_I;
            cts_q2_ff  <= cts_q1_ff;
        end
    end

    logic tick;
    assign tick = lclk_q2_ff & ~lclk_q3_ff;

    logic access;
    logic wr;
    logic rd;
    logic init_cmd;
    logic device_clear_cmd;
    logic input_read_cmd;
    logic output_flags_cmd;
    logic tx_load;
    logic sel_match;
    assign access   = PSEL_I & PENABLE_I;
    assign wr       = access & PWRITE_I & is_mapped(PADDR_I);
    assign rd       = access & ~PWRITE_I & is_mapped(PADDR_I);
    assign init_cmd = wr && PADDR_I == ADDR_W'(`SSA_OFS_CMD) && PWDATA_I[`SSA_CMD_INIT_BIT];
    assign sel_match = PWDATA_I[7:0] == SEL_ADDR;
    assign device_clear_cmd = wr && sel_ff && !init_cmd && PADDR_I == ADDR_W'(`SSA_OFS_CMD)
                              && PWDATA_I[`SSA_CMD_DEVICE_CLEAR_CMD_BIT];
    assign input_read_cmd   = rd && sel_ff && PADDR_I == ADDR_W'(`SSA_OFS_RXDATA);
    assign output_flags_cmd = wr && sel_ff && PADDR_I == ADDR_W'(`SSA_OFS_OFLAGS);
    assign tx_load = wr && sel_ff && !tx_full_ff && PADDR_I == ADDR_W'(`SSA_OFS_TXDATA);

    assign PREADY_O  = access;
    assign PSLVERR_O = access & ~is_mapped(PADDR_I);
    assign PRDATA_O  = prdata_ff;

    // Configuration registers
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_ff <= `SSA_CTRL_RST;
            sync_ff <= `SSA_SYNC_RST;
            mask_ff <= `SSA_MASK_RST;
        end else if (wr) begin
            if (PADDR_I == ADDR_W'(`SSA_OFS_CTRL)) begin
                ctrl_ff <= PWDATA_I[5:0];
            end
            if (PADDR_I == ADDR_W'(`SSA_OFS_SYNC)) begin
                sync_ff <= PWDATA_I[7:0];
            end
            if (PADDR_I == ADDR_W'(`SSA_OFS_MASK)) begin
                mask_ff <= PWDATA_I[7:0];
            end
        end
    end

    // Select, and the modem output flags
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sel_ff <= 1'b0;
            ofl_ff <= `SSA_OFL_RST;
        end else if (init_cmd) begin
            sel_ff <= 1'b0;
            ofl_ff <= `SSA_OFL_RST;
        end else begin
            if (wr && PADDR_I == ADDR_W'(`SSA_OFS_CMD) && PWDATA_I[`SSA_CMD_SEL_BIT]) begin
                sel_ff <= sel_match;
            end
            if (device_clear_cmd) begin
                ofl_ff <= `SSA_OFL_RST;
            end else if (output_flags_cmd) begin
                ofl_ff <= PWDATA_I[2:0];
            end
        end
    end

    assign RTS_O = ofl_ff.rts;
    assign DTR_O = ofl_ff.dtr;

    logic tx_last;
    logic fill_ok;
    logic sel_rise;
    assign tx_last  = tick && tx_cnt_ff <= 4'd1;
    assign fill_ok  = ~ctrl_ff.sup | (ofl_ff.rts & cts_q2_ff);
    assign sel_rise = wr && !sel_ff && PADDR_I == ADDR_W'(`SSA_OFS_CMD) && !init_cmd
                      && PWDATA_I[`SSA_CMD_SEL_BIT] && sel_match;

    // Holding buffer and transmit-needed flag
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tx_buf_ff  <= 8'h00;
            tx_full_ff <= 1'b0;
            tx_need_ff <= 1'b0;
        end else begin
            if (tx_load) begin
                tx_buf_ff  <= PWDATA_I[7:0];
                tx_full_ff <= 1'b1;
            end else if (tx_last || init_cmd) begin
                tx_full_ff <= 1'b0;
            end
            if (tx_last && tx_data_ff && tx_cnt_ff == 4'd1) begin
                tx_need_ff <= 1'b1;
            end else if (sel_rise) begin
                tx_need_ff <= 1'b1;
            end else if (tx_load) begin
                tx_need_ff <= 1'b0;
            end
        end
    end

    // Shifter: next frame is the buffered character, else sync fill, else idle mark
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tx_sh_ff   <= 9'h1FF;
            tx_cnt_ff  <= 4'd0;
            tx_data_ff <= 1'b0;
        end else if (tick) begin
            if (tx_cnt_ff > 4'd1) begin
                tx_sh_ff  <= {1'b1, tx_sh_ff[8:1]};
                tx_cnt_ff <= tx_cnt_ff - 4'd1;
            end else if (tx_full_ff) begin
                tx_sh_ff   <= build_frame(tx_buf_ff, ctrl_ff);
                tx_cnt_ff  <= frame_len(ctrl_ff);
                tx_data_ff <= 1'b1;
            end else if (fill_ok) begin
                tx_sh_ff   <= build_frame(sync_ff, ctrl_ff);
                tx_cnt_ff  <= frame_len(ctrl_ff);
                tx_data_ff <= 1'b0;
            end else begin
                tx_cnt_ff  <= 4'd0;
                tx_data_ff <= 1'b0;
            end
        end
    end

    // Break holds the line low; a mid-frame break spoils the parity at the far end
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            txd_ff <= 1'b1;
        end else begin
            txd_ff <= ofl_ff.brk ? 1'b0 : (tx_cnt_ff != 4'd0 ? tx_sh_ff[0] : 1'b1);
        end
    end
    assign TXD_O = txd_ff;

    logic [8:0] rx_nxt;
    logic [8:0] rx_frame;
    logic       rx_done;
    logic       rx_is_sync;
    logic       rx_good;
    logic       deliver;
    assign rx_nxt     = {rxd_q2_ff, rx_sh_ff[8:1]};
    assign rx_frame   = rx_nxt >> (`SSA_FRAME_MAX - frame_len(ctrl_ff));
    assign rx_is_sync = rx_frame == build_frame(sync_ff, ctrl_ff);
    assign rx_good    = rx_frame == build_frame(rx_frame[7:0], ctrl_ff);
    assign rx_done    = tick && rx_state_ff == ssa_pkg::SSA_LOCK
                        && rx_cnt_ff + 4'd1 == frame_len(ctrl_ff);
    // Fill is stripped; the flip side is that a data byte equal to sync is lost
    assign deliver    = rx_done && !rx_is_sync;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rx_sh_ff    <= 9'h1FF;
            rx_cnt_ff   <= 4'd0;
            rx_state_ff <= ssa_pkg::SSA_HUNT;
        end else if (init_cmd || device_clear_cmd) begin
            rx_cnt_ff   <= 4'd0;
            rx_state_ff <= ssa_pkg::SSA_HUNT;
        end else if (tick) begin
            rx_sh_ff <= rx_nxt;
            if (rx_state_ff == ssa_pkg::SSA_HUNT) begin
                if (rx_is_sync) begin
                    rx_state_ff <= ssa_pkg::SSA_LOCK;
                end
                rx_cnt_ff <= 4'd0;
            end else if (rx_done) begin
                rx_cnt_ff <= 4'd0;
            end else begin
                rx_cnt_ff <= rx_cnt_ff + 4'd1;
            end
        end
    end

    // Arrival wins over any clear in the same cycle
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rx_data_ff  <= 8'h00;
            rx_avail_ff <= 1'b0;
            perr_ff     <= 1'b0;
        end else if (deliver) begin
            rx_data_ff  <= rx_frame[7:0] & (8'hFF >> ctrl_ff.wcode);
            rx_avail_ff <= 1'b1;
            perr_ff     <= !rx_good || (rx_avail_ff && !input_read_cmd);
        end else begin
            if (init_cmd || device_clear_cmd || input_read_cmd) begin
                rx_avail_ff <= 1'b0;
            end
            if (init_cmd || device_clear_cmd) begin
                perr_ff <= 1'b0;
            end
        end
    end

    logic irq_rx;
    logic irq_tx;
    assign irq_rx = ctrl_ff.ien & mask_ff[`SSA_MASK_RX_BIT] & rx_avail_ff;
    assign irq_tx = ctrl_ff.ien & mask_ff[`SSA_MASK_TX_BIT] & tx_need_ff & ~tx_full_ff;

    // Pending request follows its cause; device clear drops it, but a standing transmit cause raises it again next cycle
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_ff <= 1'b0;
        end else if (init_cmd || device_clear_cmd) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irq_rx | irq_tx;
        end
    end
    assign IRQ_O = irq_ff;

    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (8'(PADDR_I))
            `SSA_OFS_CTRL:   rd_val[5:0] = ctrl_ff;
            `SSA_OFS_SYNC:   rd_val[7:0] = sync_ff;
            `SSA_OFS_MASK:   rd_val[7:0] = mask_ff;
            `SSA_OFS_OFLAGS: rd_val[2:0] = ofl_ff;
            `SSA_OFS_RXDATA: rd_val[7:0] = rx_data_ff;
            `SSA_OFS_STATUS: begin
                rd_val[`SSA_ST_RXA_BIT]  = rx_avail_ff;
                rd_val[`SSA_ST_TXN_BIT]  = tx_need_ff;
                rd_val[`SSA_ST_PERR_BIT] = perr_ff;
                rd_val[`SSA_ST_SEL_BIT]  = sel_ff;
                rd_val[`SSA_ST_CTS_BIT]  = cts_q2_ff;
                rd_val[`SSA_ST_IRQ_BIT]  = irq_ff;
                rd_val[`SSA_ST_LOCK_BIT] = rx_state_ff == ssa_pkg::SSA_LOCK;
            end
            default:         rd_val = 32'h0000_0000;
        endcase
    end

    // Read data latched in the setup phase so it stands for the access phase
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            prdata_ff <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            prdata_ff <= rd_val;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    rx_read_clr_a: assert property (input_read_cmd && !deliver |=> !rx_avail_ff)
        else $error("available flag survived a read");
    device_clear_cmd_clear_a: assert property (device_clear_cmd && !deliver
                                   |=> !rx_avail_ff && !perr_ff && !irq_ff)
        else $error("device clear left a flag set");
    init_clear_a: assert property (init_cmd && !deliver |=> !rx_avail_ff && !perr_ff && !sel_ff)
        else $error("initialize left state behind");
    hunt_block_a: assert property ($rose(rx_state_ff) |-> $past(tick && rx_is_sync))
        else $error("character delivered without sync");
    overrun_set_a: assert property (deliver && rx_avail_ff && !input_read_cmd |=> perr_ff)
        else $error("overrun not flagged");
    mask_zero_a: assert property (mask_ff[2:1] == 2'b00 [*2] |-> !IRQ_O)
        else $error("interrupt with mask zero");
    tx_full_quiet_a: assert property (!mask_ff[`SSA_MASK_RX_BIT] && tx_full_ff
                                      ##1 !mask_ff[`SSA_MASK_RX_BIT] |-> !IRQ_O)
        else $error("transmit interrupt while buffer full");
    first_sel_a: assert property (sel_rise && !tx_load |=> tx_need_ff && sel_ff)
        else $error("transmit-needed not set on select");
    fill_stop_a: assert property (tick && tx_cnt_ff <= 4'd1 && !tx_full_ff && !fill_ok
                                  |=> tx_cnt_ff == 4'd0 ##1 TXD_O || ofl_ff.brk)
        else $error("sync fill sent while suppressed");
    break_low_a: assert property (ofl_ff.brk |=> !TXD_O)
        else $error("break did not hold line low");

endmodule : ssa_top

`default_nettype wire

// file: sim/ssa_loop_plug.sv
`timescale 1ns/1ps
`default_nettype none

module ssa_loop_plug (
    input  wire logic txd_i,
    input  wire logic rts_i,
    input  wire logic cts_drop_i,
    output logic      rxd_o,
    output logic      cts_o
);
    // Plug wires transmit data back to the receiver
    assign rxd_o = txd_i;
    // Request echoed as clear-to-send; the bench may break that path
    assign cts_o = rts_i & ~cts_drop_i;
endmodule : ssa_loop_plug

`default_nettype wire

// file: sim/ssa_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssa_consts.svh"

module ssa_top_tb_top;
    logic        clk, rstn, psel, pen, pwr, lclk, rxd, cts, txd, rts, dtr, irq;
    logic        pready, pslverr, drop, err, z;
    logic [7:0]  paddr, sy, d;
    logic [5:0]  c;
    logic [31:0] pwdata, prdata, r, s;
    int          miscompares, compares, cyc, i, n;
    // Control, sync, data; syncs chosen so no rotation matches itself
    logic [21:0] rows [7] = '{{6'h00, 8'h16, 8'h55}, {6'h01, 8'h16, 8'h2A},
        {6'h02, 8'h16, 8'h2B}, {6'h03, 8'h16, 8'h0D}, {6'h04, 8'hA7, 8'hC3},
        {6'h0C, 8'hE9, 8'h3C}, {6'h0F, 8'h16, 8'h09}};

    ssa_top uut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .LCLK_I(lclk), .RXD_I(rxd),
        .CTS_I(cts), .TXD_O(txd), .RTS_O(rts), .DTR_O(dtr), .IRQ_O(irq));
    ssa_loop_plug plug (.txd_i(txd), .rts_i(rts), .cts_drop_i(drop), .rxd_o(rxd),
        .cts_o(cts));

    always #12.5 clk = ~clk;
    initial begin
        lclk = 1'b0;
        // Offset keeps the link clock out of phase with the system clock
        #7;
        forever #100 lclk = ~lclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= dv;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        // Idle cycle so the next setup never lands in the same step
        @(posedge clk);
    endtask : apb

    task automatic wst(input logic [31:0] m, input logic [31:0] v);
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, `SSA_OFS_STATUS, 32'h0);
            if ((r & m) === v) break;
        end
        s = r;
    endtask : wst

    task automatic tx(input logic [7:0] dv);
        apb(1'b1, `SSA_OFS_TXDATA, {24'h0, dv});
    endtask : tx

    task automatic ovr();
        tx(8'h55);
        wst(32'h1, 32'h1);
        tx(8'h33);
        wst(32'h4, 32'h4);
    endtask : ovr

    task automatic resync();
        // Old frame format drains first, then the clear lands between link ticks
        repeat (200) @(posedge clk);
        @(posedge lclk);
        repeat (2) @(posedge clk);
        apb(1'b1, `SSA_OFS_CMD, 32'h400);
    endtask : resync

    task automatic line_scan();
        z = 1'b0;
        // Let any frame already in flight finish first
        repeat (200) @(posedge clk);
        for (int k = 0; k < 80; k++) begin
            @(negedge clk);
            if (txd === 1'b0) z = 1'b1;
        end
        @(posedge clk);
    endtask : line_scan

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        clk = 1'b0; rstn = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; drop = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; miscompares = 0; compares = 0; cyc = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, `SSA_OFS_STATUS, 32'h0);
        chk(r & 32'hF, 32'h0);
        apb(1'b1, `SSA_OFS_CMD, 32'h1F1);
        apb(1'b0, `SSA_OFS_STATUS, 32'h0);
        chk(r & 32'h8, 32'h0);
        apb(1'b1, `SSA_OFS_CMD, 32'h1F0);
        apb(1'b0, `SSA_OFS_STATUS, 32'h0);
        chk(r & 32'hA, 32'hA);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (i = 0; i < 7; i++) begin
            {c, sy, d} = rows[i];
            apb(1'b1, `SSA_OFS_CTRL, {26'h0, c});
            apb(1'b1, `SSA_OFS_SYNC, {24'h0, sy});
            resync();
            apb(1'b0, `SSA_OFS_STATUS, 32'h0);
            chk(r & 32'h41, 32'h0);
            wst(32'h40, 32'h40);
            tx(d);
            apb(1'b0, `SSA_OFS_STATUS, 32'h0);
            chk(r & 32'h2, 32'h0);
            wst(32'h1, 32'h1);
            chk(s & 32'h7, 32'h3);
            apb(1'b0, `SSA_OFS_RXDATA, 32'h0);
            chk(r, {24'h0, d & (8'hFF >> c[1:0])});
            apb(1'b0, `SSA_OFS_STATUS, 32'h0);
            chk(r & 32'h1, 32'h0);
        end
        apb(1'b1, `SSA_OFS_CTRL, 32'h0);
        resync();
        wst(32'h40, 32'h40);
        ovr();
        chk(s & 32'h5, 32'h5);
        resync();
        apb(1'b0, `SSA_OFS_STATUS, 32'h0);
        chk(r & 32'h5, 32'h0);
        ovr();
        apb(1'b0, `SSA_OFS_RXDATA, 32'h0);
        tx(8'h5A);
        wst(32'h1, 32'h1);
        chk(s & 32'h4, 32'h0);
        tx(8'h33);
        wst(32'h4, 32'h4);
        apb(1'b1, `SSA_OFS_CMD, 32'h200);
        apb(1'b0, `SSA_OFS_STATUS, 32'h0);
        chk(r & 32'hD, 32'h0);
        apb(1'b1, `SSA_OFS_CMD, 32'h1F0);
        apb(1'b1, `SSA_OFS_CTRL, 32'h10);
        apb(1'b1, `SSA_OFS_MASK, 32'h0);
        resync();
        wst(32'h40, 32'h40);
        tx(8'h55);
        wst(32'h1, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, `SSA_OFS_RXDATA, 32'h0);
        apb(1'b1, `SSA_OFS_MASK, 32'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        tx(8'h55);
        wst(32'h1, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `SSA_OFS_CMD, 32'h400);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `SSA_OFS_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        tx(8'h55);
        tx(8'h66);
        apb(1'b0, `SSA_OFS_STATUS, 32'h0);
        chk({30'h0, irq, r[1]}, 32'h0);
        apb(1'b1, `SSA_OFS_MASK, 32'h0);
        apb(1'b1, `SSA_OFS_CTRL, 32'h20);
        apb(1'b1, `SSA_OFS_OFLAGS, 32'h0);
        line_scan();
        chk({31'h0, z}, 32'h0);
        drop <= 1'b1;
        apb(1'b1, `SSA_OFS_OFLAGS, 32'h3);
        chk({30'h0, rts, dtr}, 32'h3);
        line_scan();
        chk({31'h0, z}, 32'h0);
        drop <= 1'b0;
        line_scan();
        chk({31'h0, z}, 32'h1);
        apb(1'b1, `SSA_OFS_CTRL, 32'h0);
        apb(1'b1, `SSA_OFS_OFLAGS, 32'h0);
        line_scan();
        chk({31'h0, z}, 32'h1);
        apb(1'b1, `SSA_OFS_CTRL, 32'h0C);
        resync();
        wst(32'h40, 32'h40);
        tx(8'hFF);
        // Three bit times of ones only occur inside the all-ones frame
        n = 0;
        while (n < 24) begin
            @(negedge clk);
            n = (txd === 1'b1) ? n + 1 : 0;
        end
        @(posedge clk);
        apb(1'b1, `SSA_OFS_OFLAGS, 32'h4);
        // Break window of eight cycles spans exactly one bit sample
        repeat (5) @(posedge clk);
        apb(1'b1, `SSA_OFS_OFLAGS, 32'h0);
        wst(32'h1, 32'h1);
        chk(s & 32'h4, 32'h4);
        report_and_stop();
    end
endmodule : ssa_top_tb_top

`default_nettype wire
